/* File: hcs_strap_select.v */
// Configuration strap capture and method select with APB status view
//
// What this block does
// - Latch three method straps at reset release
// - Code 000: defaults, embedded, straps, USB LEDs
// - Code 001: SMBus slave 0101100, no straps
// - Code 010: defaults, level peripheral, no unassigned
// - Code 011: EEPROM load, LED mode loaded
// - Code 100: edge peripheral, host LEDs, unassigned
// - Code 101: edge, host+speed LEDs, no straps
// - SMBus clock pin doubles as strap bit0
// - Supply detect high means self-powered
// - Defaults sample fixed-device straps, LED polarity
`timescale 1ns/1ps
`include "hcs_defines.vh"

module hcs_strap_select (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // Strap inputs
    input  wire        config_method_strap_bit1,
    input  wire        config_method_strap_bit2,
    input  wire [1:0]  fixed_device_strap,
    input  wire        local_supply_detect,
    // Serial management clock pin, open drain
    input  wire        serial_mgmt_clock_in,
    output wire        serial_mgmt_clock_out,
    output wire        serial_mgmt_clock_oe_n,
    // Serial engine side clock request and sampled clock
    input  wire        smb_clock_hold,
    output reg         smb_clock_level,
    // Decoded configuration
    output reg  [2:0]  method_code,
    output reg  [1:0]  cfg_source,
    output reg  [1:0]  port_mode,
    output reg  [1:0]  led_mode,
    output reg         led_strap_enable,
    output reg         unassigned_ok,
    output reg         smbus_slave_enable,
    output reg  [6:0]  smbus_slave_addr,
    output reg  [3:0]  fixed_port_mask,
    output reg  [1:0]  led_active_high,
    output reg         self_powered,
    output reg         config_ready
);

    ////////////////////////////////////////////////////////////////////////
    // Strap capture

    // High in reset and in the first cycle after release; straps are caught by a clocked
    // process because an async reset may only load constants
    reg        capture_done;
    reg [2:0]  code_q;
    reg [1:0]  fixed_q;
    reg        use_strap_q;
    wire       capture = ~capture_done;

    wire [1:0] d_source;
    wire [1:0] d_pmode;
    wire [1:0] d_led;
    wire       d_strapen;
    wire       d_unassign;
    wire       d_smben;
    wire       d_reserved;

    hcs_decode u_decode (
        .code               (code_q),
        .cfg_source         (d_source),
        .port_mode          (d_pmode),
        .led_mode           (d_led),
        .led_strap_enable   (d_strapen),
        .unassigned_ok      (d_unassign),
        .smbus_slave_enable (d_smben),
        .code_reserved      (d_reserved)
    );

    // Mask of fixed ports from the two-bit strap, one low bit set per fixed port
    function [3:0] fixed_mask;
        input [1:0] s;
        begin
            case (s)
                2'h0:    fixed_mask = 4'h0;
                2'h1:    fixed_mask = 4'h1;
                2'h2:    fixed_mask = 4'h3;
                default: fixed_mask = 4'h7;
            endcase
        end
    endfunction

    // reset taken as the low level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_done <= 1'h0;
            code_q       <= `HCS_CODE_DEFAULT;
            fixed_q      <= 2'h0;
            use_strap_q  <= 1'h0;
        end else if (capture) begin
            capture_done <= 1'h1;
            code_q       <= {config_method_strap_bit2,
                             config_method_strap_bit1,
                             serial_mgmt_clock_in};
            fixed_q      <= fixed_device_strap;
            use_strap_q  <= 1'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered configuration outputs

    // Outputs are flopped so downstream logic never sees decode glitches
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            method_code        <= `HCS_CODE_DEFAULT;
            cfg_source         <= `HCS_SRC_INTERNAL;
            port_mode          <= `HCS_PMODE_EMBEDDED;
            led_mode           <= `HCS_LED_USB;
            led_strap_enable   <= 1'h0;
            unassigned_ok      <= 1'h0;
            smbus_slave_enable <= 1'h0;
            smbus_slave_addr   <= 7'h00;
            fixed_port_mask    <= 4'h0;
            led_active_high    <= 2'h0;
            self_powered       <= 1'h0;
            config_ready       <= 1'h0;
            smb_clock_level    <= 1'h1;
        end else begin
            method_code        <= code_q;
            cfg_source         <= d_source;
            port_mode          <= d_pmode;
            led_mode           <= d_led;
            led_strap_enable   <= d_strapen;
            unassigned_ok      <= d_unassign;
            smbus_slave_enable <= d_smben;
            smbus_slave_addr   <= d_smben ? `HCS_SMB_ADDR : 7'h00;
            // fixed ports only under internal defaults
            if (use_strap_q && d_source == `HCS_SRC_INTERNAL) begin
                fixed_port_mask <= fixed_mask(fixed_q);
                led_active_high <= ~fixed_q;
            end else begin
                fixed_port_mask <= 4'h0;
                led_active_high <= 2'h0;
            end
            self_powered       <= local_supply_detect;
            config_ready       <= capture_done;
            // afterwards pin is only the serial clock
            smb_clock_level    <= serial_mgmt_clock_in;
        end
    end

    // Open drain: enable low pulls the line low on a clock hold request,
    // and never during capture so the strap is read undisturbed
    assign serial_mgmt_clock_out  = 1'h0;
    assign serial_mgmt_clock_oe_n = ~(smb_clock_hold & capture_done);

    ////////////////////////////////////////////////////////////////////////
    // APB slave

    reg        ctrl_force_default;
    wire       acc    = psel & penable;
    wire       wr_acc = acc & pwrite;

    // Zero wait states; unmapped addresses answer with an error
    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `HCS_ADDR_METHOD) ||
                        (a == `HCS_ADDR_STRAPS) ||
                        (a == `HCS_ADDR_STATUS) ||
                        (a == `HCS_ADDR_CONTROL);
        end
    endfunction

    assign pready  = 1'h1;
    assign pslverr = acc & ~is_mapped(paddr);

    // Control: bit0 requests a scratch marker visible in status
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_force_default <= `HCS_CONTROL_RESET;
        end else if (wr_acc && paddr == `HCS_ADDR_CONTROL && pstrb[0]) begin
            ctrl_force_default <= pwdata[0];
        end
    end

    // Read data registered on the setup cycle, valid in the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `HCS_ADDR_METHOD: begin
                    prdata <= {1'h0, smbus_slave_addr, 5'h00,
                               d_reserved, unassigned_ok,
                               led_strap_enable, 2'h0, cfg_source,
                               2'h0, led_mode, 2'h0, port_mode,
                               1'h0, method_code};
                end
                `HCS_ADDR_STRAPS: begin
                    prdata <= {22'h000000, led_active_high,
                               fixed_port_mask, 2'h0, fixed_q};
                end
                `HCS_ADDR_STATUS: begin
                    prdata <= {28'h0000000, smb_clock_level,
                               ctrl_force_default, config_ready,
                               self_powered};
                end
                `HCS_ADDR_CONTROL: begin
                    prdata <= {31'h00000000, ctrl_force_default};
                end
                default: begin
                    prdata <= 32'h0000_0000;
                end
            endcase
        end
    end

endmodule // hcs_strap_select

/* File: hcs_defines.vh */
// Constants for the hub configuration strap selector
`ifndef HCS_DEFINES_VH
`define HCS_DEFINES_VH

// Configuration method codes {bit2,bit1,bit0}
`define HCS_CODE_DEFAULT    3'h0
`define HCS_CODE_SMBUS      3'h1
`define HCS_CODE_LEVEL      3'h2
`define HCS_CODE_EEPROM     3'h3
`define HCS_CODE_EDGE       3'h4
`define HCS_CODE_EDGE_SPEED 3'h5

// Port-owner input modes
`define HCS_PMODE_EMBEDDED  2'h0
`define HCS_PMODE_LEVEL     2'h1
`define HCS_PMODE_EDGE      2'h2

// LED modes
`define HCS_LED_USB         2'h0
`define HCS_LED_HOST        2'h1
`define HCS_LED_HOST_SPEED  2'h2
`define HCS_LED_LOADED      2'h3

// Configuration sources
`define HCS_SRC_INTERNAL    2'h0
`define HCS_SRC_SMBUS       2'h1
`define HCS_SRC_EEPROM      2'h2

// SMBus slave address, 7 bits
`define HCS_SMB_ADDR        7'h2C

// APB register byte addresses
`define HCS_ADDR_METHOD     12'h000
`define HCS_ADDR_STRAPS     12'h004
`define HCS_ADDR_STATUS     12'h008
`define HCS_ADDR_CONTROL    12'h00C

// Field positions in the method register
`define HCS_F_CODE_LSB      0
`define HCS_F_PMODE_LSB     4
`define HCS_F_LED_LSB       8
`define HCS_F_SRC_LSB       12
`define HCS_F_STRAPEN       16
`define HCS_F_UNASSIGN      17
`define HCS_F_RESERVED      18
`define HCS_F_SMBADDR_LSB   24

// Control register reset value
`define HCS_CONTROL_RESET   1'h0

`endif

/* File: hcs_decode.v */
// Combinational decode of the latched configuration method code
`timescale 1ns/1ps
`include "hcs_defines.vh"

module hcs_decode (
    // Latched code
    input  wire [2:0] code,
    // Decoded configuration
    output reg  [1:0] cfg_source,
    output reg  [1:0] port_mode,
    output reg  [1:0] led_mode,
    output reg        led_strap_enable,
    output reg        unassigned_ok,
    output reg        smbus_slave_enable,
    output reg        code_reserved
);

    // Table lookup; reserved codes fall back to internal defaults
    always @* begin
        cfg_source         = `HCS_SRC_INTERNAL;
        port_mode          = `HCS_PMODE_EMBEDDED;
        led_mode           = `HCS_LED_USB;
        led_strap_enable   = 1'h1;
        unassigned_ok      = 1'h0;
        smbus_slave_enable = 1'h0;
        code_reserved      = 1'h0;
        case (code)
            `HCS_CODE_DEFAULT: begin
                port_mode = `HCS_PMODE_EMBEDDED;
            end
            `HCS_CODE_SMBUS: begin
                cfg_source         = `HCS_SRC_SMBUS;
                led_mode           = `HCS_LED_LOADED;
                led_strap_enable   = 1'h0;
                smbus_slave_enable = 1'h1;
            end
            `HCS_CODE_LEVEL: begin
                port_mode = `HCS_PMODE_LEVEL;
            end
            `HCS_CODE_EEPROM: begin
                cfg_source       = `HCS_SRC_EEPROM;
                led_mode         = `HCS_LED_LOADED;
                led_strap_enable = 1'h0;
            end
            `HCS_CODE_EDGE: begin
                port_mode     = `HCS_PMODE_EDGE;
                led_mode      = `HCS_LED_HOST;
                unassigned_ok = 1'h1;
            end
            // edge peripheral, host and speed LEDs
            `HCS_CODE_EDGE_SPEED: begin
                port_mode        = `HCS_PMODE_EDGE;
                led_mode         = `HCS_LED_HOST_SPEED;
                led_strap_enable = 1'h0;
                unassigned_ok    = 1'h1;
            end
            default: begin
                code_reserved = 1'h1;
            end
        endcase
    end

endmodule // hcs_decode

/* File: hcs_strap_select_props.sv */
// Checker for the hub configuration strap selector
`timescale 1ns/1ps
module hcs_strap_select_props (
    // Clock, reset and bus
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire [11:0] paddr,
    input wire        pslverr,
    // Pins and decode
    input wire        local_supply_detect,
    input wire        smb_clock_hold,
    input wire        serial_mgmt_clock_oe_n,
    input wire [2:0]  method_code,
    input wire [1:0]  cfg_source,
    input wire [1:0]  port_mode,
    input wire [1:0]  led_mode,
    input wire        led_strap_enable,
    input wire        unassigned_ok,
    input wire        smbus_slave_enable,
    input wire [6:0]  smbus_slave_addr,
    input wire        self_powered,
    input wire        config_ready
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    // Outputs and ready rise on one edge, so hold is checked a cycle later
    AST_HOLD: assert property (config_ready && $past(config_ready) |->
        $stable(method_code))
        else $error("method code moved after capture");
    AST_READY: assert property ($rose(presetn) |-> ##[1:3] config_ready)
        else $error("config ready late");
    AST_DEF: assert property (config_ready && method_code == 3'h0 |->
        port_mode == 2'h0 && led_mode == 2'h0 && led_strap_enable)
        else $error("default decode wrong");
    AST_SMB: assert property (config_ready && method_code == 3'h1 |->
        smbus_slave_enable && smbus_slave_addr == 7'h2C)
        else $error("slave decode wrong");
    AST_LVL: assert property (config_ready && method_code == 3'h2 |->
        port_mode == 2'h1 && !unassigned_ok)
        else $error("level decode wrong");
    AST_ROM: assert property (config_ready && method_code == 3'h3 |->
        cfg_source == 2'h2 && led_mode == 2'h3)
        else $error("eeprom decode wrong");
    AST_EDGE: assert property (config_ready && method_code == 3'h4 |->
        port_mode == 2'h2 && led_mode == 2'h1 && unassigned_ok)
        else $error("edge decode wrong");
    AST_SPD: assert property (config_ready && method_code == 3'h5 |->
        led_mode == 2'h2 && !led_strap_enable)
        else $error("speed decode wrong");
    AST_PIN: assert property (config_ready && !smb_clock_hold |->
        serial_mgmt_clock_oe_n)
        else $error("clock pin pulled without request");
    AST_PWR: assert property (config_ready && $stable(local_supply_detect)
        [*3] |-> self_powered == local_supply_detect)
        else $error("supply detect not followed");
    AST_ERR: assert property (psel && penable && paddr > 12'h00C |-> pslverr)
        else $error("unmapped access not refused");
endmodule // hcs_strap_select_props

bind hcs_strap_select hcs_strap_select_props hcs_strap_select_props_i (
    .pclk, .presetn, .psel, .penable, .paddr, .pslverr, .local_supply_detect,
    .smb_clock_hold, .serial_mgmt_clock_oe_n, .method_code, .cfg_source,
    .port_mode, .led_mode, .led_strap_enable, .unassigned_ok,
    .smbus_slave_enable, .smbus_slave_addr, .self_powered, .config_ready);

/* File: hcs_board_model.sv */
// Board straps and open-drain serial clock pin model
`timescale 1ns/1ps
module hcs_board_model (
    // Wanted code and host pull on the clock pin
    input  wire logic [2:0] code,
    input  wire logic       host_low,
    // Device drive of the clock pin
    input  wire logic       oe_n,
    input  wire logic       drive,
    // Resolved pins
    output wire logic       bit1,
    output wire logic       bit2,
    output wire logic       scl
);
    // no reserved codes
    // Bit1 is dropped under bit2, so 11x never reaches the pins
    assign bit2 = code[2];
    assign bit1 = code[1] & ~code[2];
    assign scl = ((!oe_n && !drive) || host_low) ? 1'b0 : 1'b1;
endmodule // hcs_board_model

/* File: hcs_strap_select_tb_top.sv */
// Testbench for the hub configuration strap selector
`timescale 1ns/1ps
`include "hcs_defines.vh"
module hcs_strap_select_tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, lsd = 1'b0, host_low = 1'b1, hold = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [2:0]  code = 3'h0;
    logic [1:0]  fixed = 2'h0;
    logic        err, icfg;
    int          mismatches = 0, samples_checked = 0;
    wire         bit1, bit2, scl, oe_n, sco, pready, pslverr, lvl;
    wire         st, un, smb, sp, rdy;
    wire [31:0]  prdata;
    wire [2:0]   mc;
    wire [1:0]   src, pm, led, lah;
    wire [6:0]   sa;
    wire [3:0]   mask;
    localparam logic [8:0] EXP [6] = '{9'h004, 9'h081, 9'h024, 9'h118,
                                       9'h04E, 9'h052};
    localparam logic [8:0] MSK [6] = '{9'h1FD, 9'h185, 9'h1FF, 9'h199,
                                       9'h1FF, 9'h1FF};
    localparam logic [3:0] FMK [4] = '{4'h0, 4'h1, 4'h3, 4'h7};

    hcs_board_model hcs_board_model_i (.code, .host_low, .oe_n, .drive(sco),
        .bit1, .bit2, .scl);
    hcs_strap_select hcs_strap_select_i (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb(4'hF), .pready, .prdata, .pslverr,
        .config_method_strap_bit1(bit1), .config_method_strap_bit2(bit2),
        .fixed_device_strap(fixed), .local_supply_detect(lsd),
        .serial_mgmt_clock_in(scl), .serial_mgmt_clock_out(sco),
        .serial_mgmt_clock_oe_n(oe_n), .smb_clock_hold(hold),
        .smb_clock_level(lvl), .method_code(mc), .cfg_source(src),
        .port_mode(pm), .led_mode(led), .led_strap_enable(st),
        .unassigned_ok(un), .smbus_slave_enable(smb), .smbus_slave_addr(sa),
        .fixed_port_mask(mask), .led_active_high(lah), .self_powered(sp),
        .config_ready(rdy));
    ////////////////////////////////////////////////////////////////////////
    // Clock at 40 MHz
    // the 24MHz reference oscillator stands outside this block
    always #12.5 pclk = ~pclk;

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rst;
        presetn <= 1'b0;
        repeat (40) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask

    task automatic end_of_test;
        if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #300000;
        mismatches++;
        end_of_test;
    end

    // Every defined code, then pins and registers under the last one
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            @(posedge pclk);
            code <= i[2:0];
            fixed <= i[1:0];
            host_low <= ~i[0];
            rst();
            icfg = (i != 1 && i != 3);
            chk("code", {29'h0, mc}, 32'(i));
            chk("decode", {23'h0, {src, pm, led, st, un, smb} & MSK[i]},
                {23'h0, EXP[i]});
            chk("addr", {25'h0, sa}, (i == 1) ? 32'h2C : 32'h0);
            chk("mask", {28'h0, mask}, icfg ? {28'h0, FMK[i[1:0]]} : 32'h0);
            chk("pol", {30'h0, lah}, icfg ? {30'h0, ~i[1:0]} : 32'h0);
            apb(1'b0, `HCS_ADDR_METHOD, 32'h0);
            chk("method_reg", rd & 32'h7F000007,
                {1'b0, (i == 1) ? 7'h2C : 7'h0, 21'h0, i[2:0]});
            apb(1'b0, `HCS_ADDR_STRAPS, 32'h0);
            chk("straps_reg", rd & 32'h3F3, {22'h0, icfg ? ~i[1:0] : 2'h0,
                icfg ? FMK[i[1:0]] : 4'h0, 2'h0, i[1:0]});
            code <= i[2:0] ^ 3'h3;
            host_low <= i[0];
            repeat (3) @(posedge pclk);
            chk("held", {29'h0, mc}, 32'(i));
        end
        lsd <= 1'b1;
        host_low <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("local_supply_detect", {31'h0, sp}, 32'h1);
        lsd <= 1'b0;
        hold <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("local_supply_detect", {31'h0, sp}, 32'h0);
        chk("pin", {29'h0, oe_n, sco, lvl}, 32'h0);
        hold <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("pin", {30'h0, oe_n, lvl}, 32'h3);
        apb(1'b0, `HCS_ADDR_CONTROL, 32'h0);
        chk("control", rd, 32'h0);
        apb(1'b1, `HCS_ADDR_CONTROL, 32'h1);
        apb(1'b1, `HCS_ADDR_METHOD, 32'h0);
        apb(1'b0, `HCS_ADDR_STATUS, 32'h0);
        chk("status", rd & 32'h7, 32'h6);
        apb(1'b0, `HCS_ADDR_METHOD, 32'h0);
        chk("method_ro", rd & 32'h7, 32'h5);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        end_of_test;
    end
endmodule // hcs_strap_select_tb_top
